// >>> bench/drs_operator.sv
`timescale 1ns/1ps
module drs_operator (
  input wire logic sys_clk_i,
  output logic [7:0] term_pin_o,
  output logic [3:0] key_o,
  output logic rmt_present_o
);
  initial begin
    term_pin_o = 8'h00;
    key_o = 4'h0;
    rmt_present_o = 1'b0;
  end
  task automatic pins(input logic [7:0] v);
    @(negedge sys_clk_i);
    term_pin_o = v;
  endtask
  // Key held three cycles so the synchroniser sees one clean press
  task automatic key(input int k);
    @(negedge sys_clk_i);
    key_o[k] = 1'b1;
    repeat (3) @(negedge sys_clk_i);
    key_o[k] = 1'b0;
    repeat (4) @(negedge sys_clk_i);
  endtask
  task automatic remote(input logic v);
    @(negedge sys_clk_i);
    rmt_present_o = v;
  endtask
endmodule

// >>> bench/drs_run_select_bench.sv
`timescale 1ns/1ps
module drs_run_select_bench;
  import drs_pkg::*;
  logic sys_clk_i;
  logic rst_n_i;
  drs_cfg_s cfg;
  drs_term_fn_t fn;
  drs_presets_s pre;
  logic [7:0] st_tab [5] = '{8'h00, 8'h01, 8'hfa, 8'hfb, 8'h01};
  logic [15:0] kp;
  logic [15:0] an;
  logic [15:0] bip;
  logic [15:0] ser;
  logic [15:0] max_freq;
  logic neg;
  logic s_run;
  logic s_rev;
  logic fault;
  logic stopped;
  logic [7:0] pins;
  logic [3:0] keys;
  logic rmt;
  logic [15:0] freq;
  logic run;
  logic rev;
  logic [2:0] step;
  logic hold;
  logic cok;
  logic blk;
  int num_errors = 0;
  int checked = 0;
  always #2.5 sys_clk_i = ~sys_clk_i;
  drs_run_select #(.UPDN_TICK_CYC_P(4)) u_dut (
    .sys_clk_i, .rst_n_i, .cfg_i(cfg), .term_fn_i(fn), .presets_i(pre),
    .max_freq_i(max_freq), .term_pin_i(pins), .body_run_key_i(keys[0]),
    .body_stop_key_i(keys[1]), .rmt_run_key_i(keys[2]), .rmt_stop_key_i(keys[3]),
    .rmt_present_i(rmt), .kp_ref_i(kp), .analog_ref_i(an), .bipolar_voltage_input_i(bip),
    .bipolar_negative_i(neg), .serial_ref_i(ser), .serial_run_i(s_run),
    .serial_reverse_i(s_rev), .fault_i(fault), .motor_stopped_i(stopped),
    .freq_ref_o(freq), .run_o(run), .reverse_o(rev), .step_index_o(step), .hold_o(hold),
    .comm_cfg_ok_o(cok), .dir_blocked_o(blk)
  );
  drs_operator u_ops (.sys_clk_i, .term_pin_o(pins), .key_o(keys), .rmt_present_o(rmt));
  task automatic settle();
    repeat (5) @(negedge sys_clk_i);
  endtask
  task automatic put(input logic [7:0] v);
    u_ops.pins(v);
    settle();
  endtask
  task automatic chk_cmd(input logic er, input logic ev);
    checked++;
    if (run !== er || (er && rev !== ev)) begin
      num_errors++;
      $display("CHECK FAILED t=%0t run %b rev %b", $time, run, rev);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic note(input string s);
    $display("test %s done", s);
  endtask
  task automatic give_verdict();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (5) @(negedge sys_clk_i);
    chk_cmd(1'b0, 1'b0);
    chk_word(freq, 16'h0000);
    rst_n_i = 1'b1;
    settle();
  endtask
  initial begin
    sys_clk_i = 1'b0;
    cfg = '0;
    fn = {5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
    pre = {16'h0700, 16'h0600, 16'h0500, 16'h0400, 16'h0300, 16'h0200, 16'h0100};
    kp = 16'h0064;
    an = 16'h00c8;
    bip = 16'h012c;
    ser = 16'h0190;
    max_freq = 16'hffff;
    neg = 1'b0;
    s_run = 1'b0;
    s_rev = 1'b0;
    fault = 1'b0;
    stopped = 1'b1;
    do_reset();
    cfg.run_src = RUN_FX_RX;
    put(8'h01);
    chk_cmd(1'b1, 1'b0);
    put(8'h03);
    chk_cmd(1'b0, 1'b0);
    put(8'h02);
    chk_cmd(1'b1, 1'b1);
    put(8'h00);
    chk_cmd(1'b0, 1'b0);
    for (int k = 0; k < 8; k++) begin
      put({k[2:0], 5'h01});
      chk_word(16'(step), 16'(k));
      chk_word(freq, (k == 0) ? kp : {k[7:0], 8'h00});
    end
    put(8'he0);
    chk_word(16'(step), 16'h0000);
    put(8'h00);
    note("terminals and steps");
    for (int d = 0; d < 3; d++) begin
      for (int r = 0; r < 2; r++) begin
        logic ok;
        ok = !(d == 1 && r == 0) && !(d == 2 && r == 1);
        cfg.dir_inhibit = 2'(d);
        put(r ? 8'h02 : 8'h01);
        chk_cmd(ok, r[0]);
        chk_word(16'(blk), 16'(!ok));
        put(8'h00);
      end
    end
    cfg.dir_inhibit = INH_NONE;
    cfg.run_src = RUN_RUN_DIR;
    put(8'h01);
    chk_cmd(1'b1, 1'b0);
    put(8'h03);
    chk_cmd(1'b1, 1'b1);
    put(8'h02);
    chk_cmd(1'b0, 1'b0);
    put(8'h00);
    note("inhibit and run direction");
    cfg.run_src = RUN_FX_RX;
    cfg.freq_src = FRQ_BIPOLAR;
    put(8'h01);
    chk_cmd(1'b1, 1'b0);
    chk_word(freq, bip);
    stopped = 1'b0;
    neg = 1'b1;
    settle();
    chk_cmd(1'b0, 1'b0);
    stopped = 1'b1;
    settle();
    chk_cmd(1'b1, 1'b1);
    put(8'h00);
    neg = 1'b0;
    note("bipolar");
    cfg.freq_src = 4'h3;
    settle();
    chk_word(freq, an);
    fn[3] = FN_HOLD;
    put(8'h08);
    chk_word(16'(hold), 16'h0001);
    an = 16'h0055;
    cfg.freq_src = FRQ_SERIAL;
    settle();
    chk_word(freq, 16'h00c8);
    cfg.freq_src = FRQ_KEYPAD1;
    settle();
    chk_word(16'(hold), 16'h0000);
    put(8'h00);
    cfg.freq_src = FRQ_SERIAL;
    settle();
    chk_word(freq, ser);
    // A new link reference above the ceiling is clamped, then followed once released
    ser = 16'h0123;
    max_freq = 16'h0100;
    settle();
    chk_word(freq, 16'h0100);
    max_freq = 16'hffff;
    settle();
    chk_word(freq, 16'h0123);
    fn[2] = FN_UP;
    fn[3] = FN_DOWN;
    cfg.freq_src = FRQ_UPDN;
    u_ops.pins(8'h04);
    repeat (39) @(negedge sys_clk_i);
    put(8'h00);
    chk_word(freq, FREQ_RST + 16'h000a);
    u_ops.pins(8'h08);
    repeat (19) @(negedge sys_clk_i);
    put(8'h00);
    chk_word(freq, FREQ_RST + 16'h0005);
    u_ops.pins(8'h08);
    repeat (59) @(negedge sys_clk_i);
    put(8'h00);
    chk_word(freq, 16'h0000);
    fn[2] = 5'h02;
    fn[3] = 5'h03;
    cfg.freq_src = FRQ_KEYPAD1;
    note("reference sources");
    cfg.run_src = RUN_KEYPAD;
    cfg.dir_reverse = 1'b1;
    u_ops.key(0);
    chk_cmd(1'b1, 1'b1);
    u_ops.key(1);
    chk_cmd(1'b0, 1'b0);
    u_ops.remote(1'b1);
    u_ops.key(0);
    chk_cmd(1'b0, 1'b0);
    u_ops.key(2);
    chk_cmd(1'b1, 1'b1);
    u_ops.key(3);
    u_ops.remote(1'b0);
    kp = 16'h0000;
    u_ops.key(0);
    chk_cmd(1'b0, 1'b0);
    kp = 16'h0064;
    cfg.dir_reverse = 1'b0;
    u_ops.key(0);
    chk_cmd(1'b1, 1'b0);
    u_ops.key(1);
    note("keypad");
    cfg.run_src = RUN_SERIAL;
    s_run = 1'b1;
    s_rev = 1'b1;
    for (int c = 0; c < 5; c++) begin
      cfg.station_number = st_tab[c];
      cfg.baud_rate_code = (c == 4) ? 3'h5 : 3'h4;
      cfg.comm_protocol_select = c[0];
      settle();
      chk_word(16'(cok), 16'(c == 1 || c == 2));
      chk_cmd(c == 1 || c == 2, 1'b1);
    end
    s_run = 1'b0;
    note("serial");
    cfg.run_src = RUN_FX_RX;
    cfg.power_up_autostart = 1'b1;
    u_ops.pins(8'h01);
    do_reset();
    chk_cmd(1'b1, 1'b0);
    for (int r = 1; r >= 0; r--) begin
      cfg.restart_after_fault = r[0];
      fault = 1'b1;
      settle();
      fault = 1'b0;
      settle();
      chk_cmd(r[0], 1'b0);
    end
    cfg.power_up_autostart = 1'b0;
    do_reset();
    chk_cmd(1'b0, 1'b0);
    cfg.run_src = RUN_KEYPAD;
    cfg.power_up_autostart = 1'b1;
    do_reset();
    chk_cmd(1'b0, 1'b0);
    note("autostart and restart");
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    num_errors++;
    give_verdict();
  end
endmodule

// >>> bench/drs_run_select_sva.sv
`timescale 1ns/1ps
module drs_run_select_sva
  import drs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire drs_cfg_s cfg_i,
  input wire drs_term_fn_t term_fn_i,
  input wire logic [15:0] max_freq_i,
  input wire logic [7:0] term_pin_i,
  input wire logic [15:0] serial_ref_i,
  input wire logic [15:0] freq_ref_o,
  input wire logic run_o,
  input wire logic reverse_o,
  input wire logic [2:0] step_index_o,
  input wire logic hold_o,
  input wire logic comm_cfg_ok_o,
  input wire logic dir_blocked_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence fxrx_equal;
    cfg_i.run_src == RUN_FX_RX && term_fn_i[0] == FN_FWD_RUN && term_fn_i[1] == FN_REV_RUN
      && term_pin_i[0] == term_pin_i[1];
  endsequence
  sequence run_held;
    run_o && $past(run_o);
  endsequence
  a_serial_ref: assert property ($past(rst_n_i) && $past(rst_n_i, 2)
    && $past(cfg_i.freq_src, 2) == FRQ_SERIAL && !$past(hold_o)
    && $past(serial_ref_i, 2) <= $past(max_freq_i) && step_index_o == 3'h0
    |-> freq_ref_o == $past(serial_ref_i, 2)) else $error("serial reference not followed");
  a_comm_check: assert property ($past(rst_n_i) |-> comm_cfg_ok_o ==
    ($past(cfg_i.station_number) inside {[STATION_MIN:STATION_MAX]}
    && {5'h00, $past(cfg_i.baud_rate_code)} <= BAUD_MAX)) else $error("link check wrong");
  a_fxrx_stop: assert property (fxrx_equal [*4] |-> !run_o)
    else $error("run with equal fwd and rev terminals");
  a_inhibit_dir: assert property (run_o && $stable(cfg_i.dir_inhibit) && $past(rst_n_i) |->
    !(cfg_i.dir_inhibit == INH_FWD && !reverse_o) && !(cfg_i.dir_inhibit == INH_REV && reverse_o))
    else $error("inhibited direction running");
  a_blocked_idle: assert property (dir_blocked_o && $past(dir_blocked_o) |-> !run_o)
    else $error("run while blocked");
  a_hold_range: assert property (hold_o |->
    $past(cfg_i.freq_src) inside {[FRQ_HOLD_LO:FRQ_HOLD_HI]}) else $error("hold out of range");
  a_hold_freeze: assert property (hold_o && $past(hold_o) && step_index_o == 3'h0
    && $past(step_index_o) == 3'h0 && $past(max_freq_i) == $past(max_freq_i, 2)
    |-> $stable(freq_ref_o))
    else $error("held reference moved");
  a_dir_steady: assert property (run_held |-> reverse_o == $past(reverse_o))
    else $error("direction flipped while running");
endmodule

bind drs_run_select drs_run_select_sva u_sva (.sys_clk_i, .rst_n_i, .cfg_i, .term_fn_i,
  .max_freq_i, .term_pin_i, .serial_ref_i, .freq_ref_o, .run_o, .reverse_o, .step_index_o,
  .hold_o, .comm_cfg_ok_o, .dir_blocked_o);

// >>> include/drs_pkg.sv
package drs_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned UPDN_TICK_NS = 1000000;
  localparam int unsigned UPDN_TICK_CYC = (UPDN_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TICK_W = 20;
  localparam logic [15:0] UPDN_STEP = 16'h0001;

  // Synchroniser and power-up settle
  localparam int unsigned SYNC_W = 13;
  localparam logic [1:0] BOOT_CYC = 2'h3;
  localparam logic [1:0] BOOT_CNT_RST = 2'h0;

  // Frequency source selector values
  localparam logic [3:0] FRQ_KEYPAD1 = 4'h0;
  localparam logic [3:0] FRQ_KEYPAD2 = 4'h1;
  localparam logic [3:0] FRQ_BIPOLAR = 4'h2;
  localparam logic [3:0] FRQ_ANALOG_LO = 4'h2;
  localparam logic [3:0] FRQ_ANALOG_HI = 4'h6;
  localparam logic [3:0] FRQ_HOLD_LO = 4'h2;
  localparam logic [3:0] FRQ_HOLD_HI = 4'h7;
  localparam logic [3:0] FRQ_SERIAL = 4'h7;
  localparam logic [3:0] FRQ_UPDN = 4'h8;

  // Run command source values
  localparam logic [1:0] RUN_KEYPAD = 2'h0;
  localparam logic [1:0] RUN_FX_RX = 2'h1;
  localparam logic [1:0] RUN_RUN_DIR = 2'h2;
  localparam logic [1:0] RUN_SERIAL = 2'h3;

  // Direction inhibit values
  localparam logic [1:0] INH_NONE = 2'h0;
  localparam logic [1:0] INH_FWD = 2'h1;
  localparam logic [1:0] INH_REV = 2'h2;

  // Terminal function codes
  localparam logic [4:0] FN_FWD_RUN = 5'h00;
  localparam logic [4:0] FN_REV_RUN = 5'h01;
  localparam logic [4:0] FN_STEP0 = 5'h05;
  localparam logic [4:0] FN_STEP1 = 5'h06;
  localparam logic [4:0] FN_STEP2 = 5'h07;
  localparam logic [4:0] FN_UP = 5'h11;
  localparam logic [4:0] FN_DOWN = 5'h12;
  localparam logic [4:0] FN_HOLD = 5'h17;

  // Serial link settings limits
  localparam logic [7:0] STATION_MIN = 8'h01;
  localparam logic [7:0] STATION_MAX = 8'hfa;
  localparam logic [7:0] BAUD_MAX = 8'h04;

  // Reset values
  localparam logic [15:0] FREQ_RST = 16'h0000;
  localparam logic [2:0] STEP_RST = 3'h0;

  typedef enum logic [1:0] {
    DRS_ST_STOP = 2'b00,
    DRS_ST_RUN = 2'b01,
    DRS_ST_TURN = 2'b10
  } drs_state_e;

  typedef struct packed {
    logic [3:0] freq_src;
    logic [1:0] run_src;
    logic dir_reverse;
    logic [1:0] dir_inhibit;
    logic power_up_autostart;
    logic restart_after_fault;
    logic comm_protocol_select;
    logic [7:0] station_number;
    logic [2:0] baud_rate_code;
  } drs_cfg_s;

  typedef struct packed {
    logic [15:0] preset_speed_seven;
    logic [15:0] preset_speed_six;
    logic [15:0] preset_speed_five;
    logic [15:0] preset_speed_four;
    logic [15:0] preset_speed_three;
    logic [15:0] preset_speed_two;
    logic [15:0] preset_speed_one;
  } drs_presets_s;

  typedef logic [7:0][4:0] drs_term_fn_t;

endpackage

// >>> src/drs_run_select.sv
`timescale 1ns/1ps
module drs_run_select
  import drs_pkg::*;
#(
  parameter int unsigned UPDN_TICK_CYC_P = UPDN_TICK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire drs_cfg_s cfg_i,
  input wire drs_term_fn_t term_fn_i,
  input wire drs_presets_s presets_i,
  input wire logic [15:0] max_freq_i,
  input wire logic [7:0] term_pin_i,
  input wire logic body_run_key_i,
  input wire logic body_stop_key_i,
  input wire logic rmt_run_key_i,
  input wire logic rmt_stop_key_i,
  input wire logic rmt_present_i,
  input wire logic [15:0] kp_ref_i,
  input wire logic [15:0] analog_ref_i,
  input wire logic [15:0] bipolar_voltage_input_i,
  input wire logic bipolar_negative_i,
  input wire logic [15:0] serial_ref_i,
  input wire logic serial_run_i,
  input wire logic serial_reverse_i,
  input wire logic fault_i,
  input wire logic motor_stopped_i,
  output logic [15:0] freq_ref_o,
  output logic run_o,
  output logic reverse_o,
  output logic [2:0] step_index_o,
  output logic hold_o,
  output logic comm_cfg_ok_o,
  output logic dir_blocked_o
);

  function automatic logic in_range(input logic [7:0] val, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (val >= lo) && (val <= hi);
  endfunction

  // OR of all synchronised terminals that carry the given function code
  function automatic logic term_has(input logic [7:0] pins, input drs_term_fn_t fn,
                                    input logic [4:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (fn[i] == code) begin
        hit = hit | pins[i];
      end
    end
    term_has = hit;
  endfunction

  logic [SYNC_W-1:0] sync_w;
  logic [7:0] term_w;
  logic body_run_w;
  logic body_stop_w;
  logic rmt_run_w;
  logic rmt_stop_w;
  logic rmt_present_w;

  drs_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({rmt_present_i, rmt_stop_key_i, rmt_run_key_i, body_stop_key_i,
              body_run_key_i, term_pin_i}),
    .sync_o(sync_w)
  );

  assign term_w = sync_w[7:0];
  assign body_run_w = sync_w[8];
  assign body_stop_w = sync_w[9];
  assign rmt_run_w = sync_w[10];
  assign rmt_stop_w = sync_w[11];
  assign rmt_present_w = sync_w[12];

  logic fx_w;
  logic rx_w;
  logic up_w;
  logic down_w;
  logic hold_req_w;
  logic [2:0] step_sel_w;

  assign fx_w = term_has(term_w, term_fn_i, FN_FWD_RUN);
  assign rx_w = term_has(term_w, term_fn_i, FN_REV_RUN);
  assign up_w = term_has(term_w, term_fn_i, FN_UP);
  assign down_w = term_has(term_w, term_fn_i, FN_DOWN);
  assign hold_req_w = term_has(term_w, term_fn_i, FN_HOLD);
  assign step_sel_w = {term_has(term_w, term_fn_i, FN_STEP2),
                       term_has(term_w, term_fn_i, FN_STEP1),
                       term_has(term_w, term_fn_i, FN_STEP0)};

  // Key press edges; remote keys take over when the remote is present
  logic run_key_w;
  logic stop_key_w;
  logic run_key_q_ff;
  logic stop_key_q_ff;
  logic run_press_w;
  logic stop_press_w;

  assign run_key_w = rmt_present_w ? rmt_run_w : body_run_w;
  assign stop_key_w = rmt_present_w ? rmt_stop_w : body_stop_w;
  assign run_press_w = run_key_w & ~run_key_q_ff;
  assign stop_press_w = stop_key_w & ~stop_key_q_ff;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      run_key_q_ff <= 1'b0;
      stop_key_q_ff <= 1'b0;
    end else begin
      run_key_q_ff <= run_key_w;
      stop_key_q_ff <= stop_key_w;
    end
  end

  // Link settings check
  logic comm_ok_w;
  logic comm_ok_ff;

  assign comm_ok_w = in_range(cfg_i.station_number, STATION_MIN, STATION_MAX) &&
                     in_range({5'h00, cfg_i.baud_rate_code}, 8'h00, BAUD_MAX);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      comm_ok_ff <= 1'b0;
    end else begin
      comm_ok_ff <= comm_ok_w;
    end
  end

  // Up-down reference with a fixed tick
  logic [TICK_W-1:0] tick_cnt_ff;
  logic tick_w;
  logic [15:0] updn_ref_ff;
  logic [16:0] updn_sum_w;

  assign tick_w = (tick_cnt_ff == TICK_W'(UPDN_TICK_CYC_P - 1));
  assign updn_sum_w = {1'b0, updn_ref_ff} + {1'b0, UPDN_STEP};

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      tick_cnt_ff <= '0;
    end else if (tick_w) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      updn_ref_ff <= FREQ_RST;
    end else if (cfg_i.freq_src == FRQ_UPDN && tick_w && (up_w ^ down_w)) begin
      if (up_w) begin
        updn_ref_ff <= (updn_sum_w > {1'b0, max_freq_i}) ? max_freq_i
                                                          : updn_sum_w[15:0];
      end else if (updn_ref_ff > UPDN_STEP) begin
        updn_ref_ff <= updn_ref_ff - UPDN_STEP;
      end else begin
        updn_ref_ff <= FREQ_RST;
      end
    end
  end

  // Base reference with hold for the analog, bipolar and serial sources
  logic hold_act_w;
  logic [15:0] nxt_base;
  logic [15:0] base_ff;
  logic hold_ff;

  assign hold_act_w = hold_req_w &&
                      in_range({4'h0, cfg_i.freq_src}, {4'h0, FRQ_HOLD_LO},
                               {4'h0, FRQ_HOLD_HI});

  always_comb begin
    nxt_base = kp_ref_i;
    if (cfg_i.freq_src == FRQ_SERIAL) begin
      nxt_base = serial_ref_i;
    end else if (cfg_i.freq_src == FRQ_UPDN) begin
      nxt_base = updn_ref_ff;
    end else if (cfg_i.freq_src == FRQ_BIPOLAR) begin
      nxt_base = bipolar_voltage_input_i;
    end else if (in_range({4'h0, cfg_i.freq_src}, {4'h0, FRQ_ANALOG_LO},
                          {4'h0, FRQ_ANALOG_HI})) begin
      nxt_base = analog_ref_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      base_ff <= FREQ_RST;
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= hold_act_w;
      if (!hold_act_w) begin
        base_ff <= nxt_base;
      end
    end
  end

  // Power-up settle lets the synchronisers fill before arming is judged
  logic [1:0] boot_cnt_ff;
  logic booting_w;
  logic fault_q_ff;
  logic fault_clear_w;
  logic armed_ff;
  logic term_on_w;

  assign booting_w = (boot_cnt_ff != BOOT_CYC);
  assign fault_clear_w = fault_q_ff & ~fault_i;
  assign term_on_w = (cfg_i.run_src == RUN_FX_RX) ? (fx_w | rx_w) : fx_w;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      boot_cnt_ff <= BOOT_CNT_RST;
      fault_q_ff <= 1'b0;
    end else begin
      fault_q_ff <= fault_i;
      if (booting_w) begin
        boot_cnt_ff <= boot_cnt_ff + 2'h1;
      end
    end
  end

  // A terminal already on must be released first unless restart is allowed
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      armed_ff <= 1'b0;
    end else if (booting_w) begin
      armed_ff <= cfg_i.power_up_autostart;
    end else if (fault_clear_w) begin
      armed_ff <= cfg_i.restart_after_fault | ~term_on_w;
    end else if (fault_i) begin
      armed_ff <= ~term_on_w;
    end else if (!term_on_w) begin
      armed_ff <= 1'b1;
    end
  end

  // Keypad run latch
  logic kp_run_ff;
  logic [15:0] target_w;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      kp_run_ff <= 1'b0;
    end else if (fault_i || cfg_i.run_src != RUN_KEYPAD) begin
      kp_run_ff <= 1'b0;
    end else if (stop_press_w) begin
      kp_run_ff <= 1'b0;
    end else if (run_press_w && target_w != FREQ_RST) begin
      kp_run_ff <= 1'b1;
    end
  end

  // Command decode per run source
  logic cmd_run_w;
  logic cmd_rev_w;
  logic eff_rev_w;
  logic blocked_w;
  logic want_run_w;

  always_comb begin
    cmd_run_w = 1'b0;
    cmd_rev_w = 1'b0;
    case (cfg_i.run_src)
      RUN_KEYPAD: begin
        cmd_run_w = kp_run_ff;
        cmd_rev_w = cfg_i.dir_reverse;
      end
      RUN_FX_RX: begin
        cmd_run_w = (fx_w ^ rx_w) & armed_ff;
        cmd_rev_w = rx_w;
      end
      RUN_RUN_DIR: begin
        cmd_run_w = fx_w & armed_ff;
        cmd_rev_w = rx_w;
      end
      default: begin
        cmd_run_w = serial_run_i & comm_ok_w;
        cmd_rev_w = serial_reverse_i;
      end
    endcase
  end

  assign eff_rev_w = cmd_rev_w ^ ((cfg_i.freq_src == FRQ_BIPOLAR) & bipolar_negative_i);
  assign blocked_w = ((cfg_i.dir_inhibit == INH_FWD) & ~eff_rev_w) |
                     ((cfg_i.dir_inhibit == INH_REV) & eff_rev_w);
  assign want_run_w = cmd_run_w & ~blocked_w & ~fault_i;

  // Step index and target frequency
  logic [2:0] step_w;

  assign step_w = cmd_run_w ? step_sel_w : STEP_RST;

  always_comb begin
    case (step_w)
      3'h1: target_w = presets_i.preset_speed_one;
      3'h2: target_w = presets_i.preset_speed_two;
      3'h3: target_w = presets_i.preset_speed_three;
      3'h4: target_w = presets_i.preset_speed_four;
      3'h5: target_w = presets_i.preset_speed_five;
      3'h6: target_w = presets_i.preset_speed_six;
      3'h7: target_w = presets_i.preset_speed_seven;
      default: target_w = base_ff;
    endcase
    if (target_w > max_freq_i) begin
      target_w = max_freq_i;
    end
  end

  logic [15:0] freq_ff;
  logic [2:0] step_ff;
  logic blocked_ff;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      freq_ff <= FREQ_RST;
      step_ff <= STEP_RST;
      blocked_ff <= 1'b0;
    end else begin
      freq_ff <= target_w;
      step_ff <= step_w;
      blocked_ff <= cmd_run_w & blocked_w;
    end
  end

  // Run and direction sequencer; a direction change passes through a stop
  drs_state_e st_ff;
  logic run_ff;
  logic rev_ff;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_ff <= DRS_ST_STOP;
      run_ff <= 1'b0;
      rev_ff <= 1'b0;
    end else begin
      case (st_ff)
        DRS_ST_STOP: begin
          run_ff <= 1'b0;
          if (want_run_w) begin
            if (eff_rev_w == rev_ff || motor_stopped_i) begin
              st_ff <= DRS_ST_RUN;
              run_ff <= 1'b1;
              rev_ff <= eff_rev_w;
            end else begin
              st_ff <= DRS_ST_TURN;
            end
          end
        end
        DRS_ST_RUN: begin
          if (!want_run_w) begin
            st_ff <= DRS_ST_STOP;
            run_ff <= 1'b0;
          end else if (eff_rev_w != rev_ff) begin
            st_ff <= DRS_ST_TURN;
            run_ff <= 1'b0;
          end
        end
        DRS_ST_TURN: begin
          run_ff <= 1'b0;
          if (!want_run_w) begin
            st_ff <= DRS_ST_STOP;
          end else if (motor_stopped_i) begin
            st_ff <= DRS_ST_RUN;
            run_ff <= 1'b1;
            rev_ff <= eff_rev_w;
          end
        end
        default: begin
          st_ff <= DRS_ST_STOP;
          run_ff <= 1'b0;
        end
      endcase
    end
  end

  assign freq_ref_o = freq_ff;
  assign run_o = run_ff;
  assign reverse_o = rev_ff;
  assign step_index_o = step_ff;
  assign hold_o = hold_ff;
  assign comm_cfg_ok_o = comm_ok_ff;
  assign dir_blocked_o = blocked_ff;

endmodule

// >>> src/drs_sync.sv
`timescale 1ns/1ps
module drs_sync
  import drs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [SYNC_W-1:0] async_i,
  output logic [SYNC_W-1:0] sync_o
);

  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;

  // Two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule
